// ===== rtl/cswk_map.vh
// register offsets, field positions, reset values and timing counts of the wake control block
`ifndef CSWK_MAP_VH
`define CSWK_MAP_VH

// register offsets
`define CSWK_MODE      8'h00
`define CSWK_STAT      8'h01
`define CSWK_ECNT      8'h02
`define CSWK_CTRL      8'h03
`define CSWK_QPB       8'h04
`define CSWK_SPT       8'h05
`define CSWK_CLKSEL    8'h06
`define CSWK_FDFILT    8'h07
`define CSWK_OSC_H     8'h08
`define CSWK_OSC_L     8'h09
`define CSWK_TRIM      8'h0a
`define CSWK_OPT       8'h0b
`define CSWK_ID_W      6'h04
`define CSWK_MASK_W    6'h05
`define CSWK_PAY_D     5'h03

// status bits
`define CSWK_ST_BWAKE  0
`define CSWK_ST_WUP    1
`define CSWK_ST_WUF    2
`define CSWK_ST_CFGERR 3
`define CSWK_ST_SIL    4

// control bits
`define CSWK_CT_FDEN   0
`define CSWK_CT_HOLD   1
`define CSWK_CT_RXSEL  2
`define CSWK_CT_MEAS   3
`define CSWK_CT_UNLK   5:4

// mode codes
`define CSWK_M_OFF     3'h0
`define CSWK_M_WK      3'h1
`define CSWK_M_SWK     3'h5

// reset values, counter overflow value and unlock code
`define CSWK_QPB_RST   6'h0a
`define CSWK_SPT_RST   6'h33
`define CSWK_FDF_RST   8'h04
`define CSWK_ECNT_OVF  6'h20
`define CSWK_UNLOCKED  2'h3

// timing
`define CSWK_CLK_HZ    50000000
`define CSWK_T_SIL_MS  600
`define CSWK_SIL_CYC   ((`CSWK_CLK_HZ / 1000) * `CSWK_T_SIL_MS)

`endif

// ===== rtl/cswk_ctrl.v
// selective-wake control: mode remap, wake flags, error counter, frame match, oscillator measure
`timescale 1ns/1ps
`include "cswk_map.vh"

//Contract
//- restart from normal: mode 010/011 becomes 001, config error cleared
//- restart from normal: modes 101/110/111 read 101, config error set; off stays off
//- pattern wake in plain wake mode keeps 001, sets bus wake and pattern flags
//- wake from other source leaves mode and bus wake flags alone
//- frame wake inside silence sets frame and pattern flags, else frame flag only
//- counter overflow in selective sleep wakes, sets config error and bus wake, count 100000
//- pattern flag may stay clear after silence, e.g. on counter overflow
//- fail-safe entry forces wake-capable mode without selective wake
//- bus wake restarts when asleep, interrupts in normal or stop
//- any bus wake sets bus wake flag; details readable in flags and count
//- decoder quanta from timing register scaled by clock select, sample point, receiver select
//- frame match uses programmed id, id mask and payload
//- measure enable in mode 000/100 counts low pulse on transmit pin into high and low registers
//- trim writes only with unlock 11 and measure enable; host relocks with 00
//- fd tolerant: skip data phase, no error handling, no wake on fd frames
//- edl 1 marks fd frame and stops decoding; edl 0 handled as classic
//- after fd frame decoder is ready again at its end of frame
//- fd tolerant uses programmable minimum dominant filter
//- fd tolerant off: count up on fd or bad frames, down on good ones
//- fd tolerant on, hold 0: count down on every good frame incl fd
//- fd tolerant and hold both 1: counter cleared and held at zero
//- hold bit cleared when silence timeout expires
//- mode code 000/100 off, 001 wake, 010 rx only, 011 normal, 101/110/111 with selective wake
//- config error 0 means selective wake enabled and no overflow seen
module cswk_ctrl #(
    parameter SIL_CYCLES = `CSWK_SIL_CYC
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        in_sleep,
    input  wire        in_normal,
    input  wire        in_stop,
    input  wire        restart_from_normal,
    input  wire        fail_safe_entry,
    input  wire        wake_pattern_det,
    input  wire        frame_edl,
    input  wire        frame_ok,
    input  wire        frame_err,
    input  wire        frame_eof,
    input  wire [31:0] rx_id,
    input  wire [63:0] rx_data,
    input  wire        rx_pin_a,
    input  wire        rx_pin_b,
    input  wire        transmit_data_pin,
    output reg  [2:0]  trx_mode,
    output reg         selective_wake,
    output reg  [7:0]  tq_per_bit,
    output reg  [5:0]  sample_point_cfg,
    output reg         fd_tolerant_en,
    output reg         fd_dom_bit,
    output reg         fd_skip,
    output reg  [7:0]  osc_trim_value,
    output reg  [7:0]  osc_trim_option,
    output reg         restart_req,
    output reg         wake_irq
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg [2:0]  mode;
reg        bus_wake_flag;
reg        wup_flag;
reg        wuf_flag;
reg        swk_config_error;
reg [5:0]  frame_error_count;
reg        error_count_hold;
reg        frame_detect_receiver_sel;
reg        osc_measure_en;
reg [1:0]  trim_unlock;
reg [5:0]  quanta_per_bit_cfg;
reg [1:0]  clk_sel;
reg [7:0]  fd_tolerant_cfg;
reg [15:0] osc_count;
reg [15:0] osc_meas;
reg [31:0] wake_id_cfg;
reg [31:0] wake_id_mask_cfg;
reg [63:0] wake_payload_cfg;
reg [25:0] sil_cnt;
reg        silence;
reg [2:0]  tx_sync;
reg [1:0]  rxa_sync;
reg [1:0]  rxb_sync;
reg [7:0]  dom_cnt;

// ------------------------------------------------------------
// combinational helpers
// ------------------------------------------------------------
wire wr_mode = reg_wr && (reg_addr == `CSWK_MODE);
wire wr_stat = reg_wr && (reg_addr == `CSWK_STAT);
wire wr_ctrl = reg_wr && (reg_addr == `CSWK_CTRL);
wire unlocked = (trim_unlock == `CSWK_UNLOCKED) && osc_measure_en;
wire swk_on = mode[2] && (mode[1:0] != 2'h0) && !swk_config_error;
wire rx_sel = frame_detect_receiver_sel ? rxb_sync[1] : rxa_sync[1];
wire dominant = !rx_sel;
wire id_hit = (((rx_id ^ wake_id_cfg) & ~wake_id_mask_cfg) == 32'h0000_0000);
wire pay_hit = (wake_payload_cfg == 64'h0) || ((rx_data & wake_payload_cfg) != 64'h0);
wire good_classic = frame_ok && !fd_skip;
wire fd_frame = frame_edl && !fd_skip;
wire wuf_event = in_sleep && swk_on && good_classic && id_hit && pay_hit;
wire wup_event = wake_pattern_det && (in_sleep ? (mode == `CSWK_M_WK) || (mode[2] && mode[1:0] != 2'h0 && !swk_on)
                                               : (mode != `CSWK_M_OFF) && (mode[1:0] != 2'h0));
wire ovf_event = in_sleep && swk_on && (frame_error_count == `CSWK_ECNT_OVF - 6'h01)
                 && (fd_tolerant_en ? (frame_err && !fd_skip) : (frame_err || fd_frame));
wire any_wake = wuf_event || wup_event || ovf_event;

// ------------------------------------------------------------
// synchronisers and bus silence
// ------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        tx_sync  <= 3'h7;
        rxa_sync <= 2'h3;
        rxb_sync <= 2'h3;
        sil_cnt  <= 26'h0;
        silence  <= 1'b0;
    end else begin
        tx_sync  <= {tx_sync[1:0], transmit_data_pin};
        rxa_sync <= {rxa_sync[0], rx_pin_a};
        rxb_sync <= {rxb_sync[0], rx_pin_b};
        // a dominant level on the selected receiver restarts the silence timer
        if (dominant) begin
            sil_cnt <= 26'h0;
            silence <= 1'b0;
        end else if (sil_cnt == SIL_CYCLES[25:0] - 26'h1) begin
            silence <= 1'b1;
        end else begin
            sil_cnt <= sil_cnt + 26'h1;
        end
    end
end

// ------------------------------------------------------------
// fd tolerant decoding support
// ------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        dom_cnt    <= 8'h00;
        fd_dom_bit <= 1'b0;
        fd_skip    <= 1'b0;
    end else begin
        fd_dom_bit <= 1'b0;
        if (!dominant) begin
            dom_cnt <= 8'h00;
        end else if (dom_cnt != 8'hff) begin
            dom_cnt <= dom_cnt + 8'h01;
        end
        if (fd_tolerant_en && dominant && (dom_cnt + 8'h01 == fd_tolerant_cfg)) begin
            fd_dom_bit <= 1'b1;
        end
        if (frame_eof) begin
            fd_skip <= 1'b0;
        end else if (frame_edl && fd_tolerant_en) begin
            fd_skip <= 1'b1;
        end
    end
end

// ------------------------------------------------------------
// oscillator pulse measurement
// ------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        osc_count <= 16'h0000;
        osc_meas  <= 16'h0000;
    end else if (osc_measure_en && (mode[1:0] == 2'h0)) begin
        if (tx_sync[2] && !tx_sync[1]) begin
            osc_count <= 16'h0001;
        end else if (!tx_sync[1] && osc_count != 16'hffff) begin
            osc_count <= osc_count + 16'h0001;
        end else if (!tx_sync[2] && tx_sync[1]) begin
            osc_meas <= osc_count;
        end
    end
end

// ------------------------------------------------------------
// modes, flags, counter and registers
// ------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        mode                      <= `CSWK_M_OFF;
        bus_wake_flag             <= 1'b0;
        wup_flag                  <= 1'b0;
        wuf_flag                  <= 1'b0;
        swk_config_error          <= 1'b1;
        frame_error_count         <= 6'h00;
        error_count_hold          <= 1'b0;
        frame_detect_receiver_sel <= 1'b0;
        osc_measure_en            <= 1'b0;
        trim_unlock               <= 2'h0;
        fd_tolerant_en            <= 1'b0;
        quanta_per_bit_cfg        <= `CSWK_QPB_RST;
        sample_point_cfg          <= `CSWK_SPT_RST;
        clk_sel                   <= 2'h0;
        fd_tolerant_cfg           <= `CSWK_FDF_RST;
        osc_trim_value            <= 8'h00;
        osc_trim_option           <= 8'h00;
        wake_id_cfg               <= 32'h0;
        wake_id_mask_cfg          <= 32'h0;
        wake_payload_cfg          <= 64'h0;
    end else begin
        // host writes first, hardware events below override them
        if (wr_mode) begin
            mode <= reg_wdata[2:0];
        end
        if (wr_stat) begin
            bus_wake_flag    <= bus_wake_flag & ~reg_wdata[`CSWK_ST_BWAKE];
            wup_flag         <= wup_flag & ~reg_wdata[`CSWK_ST_WUP];
            wuf_flag         <= wuf_flag & ~reg_wdata[`CSWK_ST_WUF];
            swk_config_error <= swk_config_error & ~reg_wdata[`CSWK_ST_CFGERR];
        end
        if (wr_ctrl) begin
            fd_tolerant_en            <= reg_wdata[`CSWK_CT_FDEN];
            error_count_hold          <= reg_wdata[`CSWK_CT_HOLD];
            frame_detect_receiver_sel <= reg_wdata[`CSWK_CT_RXSEL];
            osc_measure_en            <= reg_wdata[`CSWK_CT_MEAS];
            trim_unlock               <= reg_wdata[`CSWK_CT_UNLK];
        end
        if (reg_wr) begin
            case (reg_addr)
                `CSWK_QPB:    quanta_per_bit_cfg <= reg_wdata[5:0];
                `CSWK_SPT:    sample_point_cfg   <= reg_wdata[5:0];
                `CSWK_CLKSEL: clk_sel            <= reg_wdata[1:0];
                `CSWK_FDFILT: fd_tolerant_cfg    <= reg_wdata;
                `CSWK_TRIM: begin
                    if (unlocked) osc_trim_value <= reg_wdata;
                end
                `CSWK_OPT: begin
                    if (unlocked) osc_trim_option <= reg_wdata;
                end
                default: begin
                    if (reg_addr[7:2] == `CSWK_ID_W) begin
                        wake_id_cfg[{reg_addr[1:0], 3'b000} +: 8] <= reg_wdata;
                    end
                    if (reg_addr[7:2] == `CSWK_MASK_W) begin
                        wake_id_mask_cfg[{reg_addr[1:0], 3'b000} +: 8] <= reg_wdata;
                    end
                    if (reg_addr[7:3] == `CSWK_PAY_D) begin
                        wake_payload_cfg[{reg_addr[2:0], 3'b000} +: 8] <= reg_wdata;
                    end
                end
            endcase
        end

        // error counter
        if (fd_tolerant_en && error_count_hold) begin
            frame_error_count <= 6'h00;
        end else if (fd_tolerant_en) begin
            if (frame_err && !fd_skip && frame_error_count != `CSWK_ECNT_OVF) begin
                frame_error_count <= frame_error_count + 6'h01;
            end else if ((good_classic || fd_frame) && frame_error_count != 6'h00) begin
                frame_error_count <= frame_error_count - 6'h01;
            end
        end else begin
            if ((frame_err || frame_edl) && frame_error_count != `CSWK_ECNT_OVF) begin
                frame_error_count <= frame_error_count + 6'h01;
            end else if (frame_ok && frame_error_count != 6'h00) begin
                frame_error_count <= frame_error_count - 6'h01;
            end
        end
        if (!dominant && !silence && sil_cnt == SIL_CYCLES[25:0] - 26'h1) begin
            error_count_hold <= 1'b0;
        end

        // wake flags, set wins over a same-cycle clear
        if (any_wake) begin
            bus_wake_flag <= 1'b1;
        end
        if (wup_event) begin
            wup_flag <= 1'b1;
        end
        if (wuf_event) begin
            wuf_flag <= 1'b1;
            if (silence) begin
                wup_flag <= 1'b1;
            end
        end
        if (ovf_event) begin
            swk_config_error  <= 1'b1;
            frame_error_count <= `CSWK_ECNT_OVF;
        end

        // mode remapping on operating mode changes
        if (restart_from_normal) begin
            if (mode[2] && mode[1:0] != 2'h0) begin
                mode             <= `CSWK_M_SWK;
                swk_config_error <= 1'b1;
            end else if (!mode[2] && mode[1]) begin
                mode             <= `CSWK_M_WK;
                swk_config_error <= 1'b0;
            end
        end
        if (fail_safe_entry) begin
            mode <= `CSWK_M_WK;
        end
    end
end

// ------------------------------------------------------------
// outputs and read port
// ------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        reg_rdata      <= 8'h00;
        trx_mode       <= `CSWK_M_OFF;
        selective_wake <= 1'b0;
        tq_per_bit     <= 8'h00;
        restart_req    <= 1'b0;
        wake_irq       <= 1'b0;
    end else begin
        trx_mode       <= mode;
        selective_wake <= swk_on;
        tq_per_bit     <= {2'b00, quanta_per_bit_cfg} << clk_sel;
        // other wake sources never touch these flags
        restart_req    <= any_wake && in_sleep;
        wake_irq       <= any_wake && !in_sleep && (in_normal || in_stop);
        reg_rdata      <= 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `CSWK_MODE:   reg_rdata <= {5'h00, mode};
                `CSWK_STAT:   reg_rdata <= {3'h0, silence, swk_config_error, wuf_flag, wup_flag, bus_wake_flag};
                `CSWK_ECNT:   reg_rdata <= {2'h0, frame_error_count};
                `CSWK_CTRL:   reg_rdata <= {2'h0, trim_unlock, osc_measure_en, frame_detect_receiver_sel,
                                            error_count_hold, fd_tolerant_en};
                `CSWK_QPB:    reg_rdata <= {2'h0, quanta_per_bit_cfg};
                `CSWK_SPT:    reg_rdata <= {2'h0, sample_point_cfg};
                `CSWK_CLKSEL: reg_rdata <= {6'h00, clk_sel};
                `CSWK_FDFILT: reg_rdata <= fd_tolerant_cfg;
                `CSWK_OSC_H:  reg_rdata <= osc_meas[15:8];
                `CSWK_OSC_L:  reg_rdata <= osc_meas[7:0];
                `CSWK_TRIM:   reg_rdata <= osc_trim_value;
                `CSWK_OPT:    reg_rdata <= osc_trim_option;
                default: begin
                    if (reg_addr[7:2] == `CSWK_ID_W) begin
                        reg_rdata <= wake_id_cfg[{reg_addr[1:0], 3'b000} +: 8];
                    end else if (reg_addr[7:2] == `CSWK_MASK_W) begin
                        reg_rdata <= wake_id_mask_cfg[{reg_addr[1:0], 3'b000} +: 8];
                    end else if (reg_addr[7:3] == `CSWK_PAY_D) begin
                        reg_rdata <= wake_payload_cfg[{reg_addr[2:0], 3'b000} +: 8];
                    end
                end
            endcase
        end
    end
end

endmodule

// ===== tb/cswk_ctrl_monitor.sv
// port-level assertions for the selective-wake control block
`timescale 1ns/1ps
module cswk_ctrl_monitor (
    input wire       ref_clk,
    input wire       rstn,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       in_sleep,
    input wire       in_normal,
    input wire       in_stop,
    input wire       restart_from_normal,
    input wire       fail_safe_entry,
    input wire       wake_pattern_det,
    input wire [2:0] trx_mode,
    input wire       selective_wake,
    input wire       fd_tolerant_en,
    input wire       fd_skip,
    input wire       restart_req,
    input wire       wake_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_rst_sleep; restart_req |-> $past(in_sleep); endproperty
    a_rst_sleep: assert property (p_rst_sleep) else $error("restart request while awake");
    property p_irq_mode; wake_irq |-> $past(in_normal) || $past(in_stop); endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("wake interrupt outside normal or stop");
    property p_wup_sleep; in_sleep && wake_pattern_det && trx_mode == 3'h1 |=> restart_req; endproperty
    a_wup_sleep: assert property (p_wup_sleep) else $error("pattern wake gave no restart");
    property p_wup_stop; in_stop && wake_pattern_det && trx_mode == 3'h1 |=> wake_irq; endproperty
    a_wup_stop: assert property (p_wup_stop) else $error("pattern wake gave no interrupt");
    property p_plain; restart_from_normal && trx_mode[2:1] == 2'h1 |-> ##2 trx_mode == 3'h1; endproperty
    a_plain: assert property (p_plain) else $error("plain mode not remapped to 001");
    property p_swk;
        restart_from_normal && trx_mode[2] && trx_mode[1:0] != 2'h0 |-> ##2 trx_mode == 3'h5 && !selective_wake;
    endproperty
    a_swk: assert property (p_swk) else $error("selective mode not remapped to 101");
    property p_off; restart_from_normal && trx_mode[1:0] == 2'h0 |-> ##2 $stable(trx_mode); endproperty
    a_off: assert property (p_off) else $error("off mode changed on restart");
    property p_fs; fail_safe_entry |-> ##2 !selective_wake; endproperty
    a_fs: assert property (p_fs) else $error("selective wake kept in fail-safe");
    property p_skip; fd_skip |-> fd_tolerant_en; endproperty
    a_skip: assert property (p_skip) else $error("frame skipped without tolerant mode");
    property p_sel; selective_wake |-> trx_mode[2] && trx_mode[1:0] != 2'h0; endproperty
    a_sel: assert property (p_sel) else $error("selective wake in a plain mode");

    c_restart: cover property (restart_req);
    c_irq: cover property (wake_irq);
    c_skip: cover property (fd_skip);
endmodule

bind cswk_ctrl cswk_ctrl_monitor i_cswk_ctrl_monitor (.ref_clk(ref_clk), .rstn(rstn), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_sleep(in_sleep), .in_normal(in_normal), .in_stop(in_stop),
    .restart_from_normal(restart_from_normal), .fail_safe_entry(fail_safe_entry),
    .wake_pattern_det(wake_pattern_det), .trx_mode(trx_mode), .selective_wake(selective_wake),
    .fd_tolerant_en(fd_tolerant_en), .fd_skip(fd_skip), .restart_req(restart_req), .wake_irq(wake_irq));

// ===== tb/cswk_bus_node.sv
// model of another bus node: frame events and receiver lines
`timescale 1ns/1ps
module cswk_bus_node #(
    parameter logic [31:0] FRAME_ID = 32'h0
) (
    input  wire         ref_clk,
    output logic        wake_pattern_det = 1'b0,
    output logic        frame_edl = 1'b0,
    output logic        frame_ok = 1'b0,
    output logic        frame_err = 1'b0,
    output logic        frame_eof = 1'b0,
    output logic [31:0] rx_id = 32'hffff_ffff,
    output logic [63:0] rx_data = 64'hffff_ffff_ffff_ffff,
    output logic        rx_pin_a = 1'b1,
    output logic        rx_pin_b = 1'b1
);
    // kind: 0 wake pattern, 1 good frame, 2 corrupted frame, 3 fd frame
    task automatic send(input logic [1:0] kind);
        rx_id <= FRAME_ID;
        rx_data <= 64'h0;
        rx_pin_a <= 1'b0;
        rx_pin_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rx_pin_a <= 1'b1;
        rx_pin_b <= 1'b1;
        wake_pattern_det <= (kind == 2'd0);
        frame_ok <= (kind == 2'd1);
        frame_err <= (kind == 2'd2);
        frame_edl <= (kind == 2'd3);
        @(posedge ref_clk);
        wake_pattern_det <= 1'b0;
        frame_ok <= 1'b0;
        frame_err <= 1'b0;
        frame_edl <= 1'b0;
        frame_eof <= 1'b1;
        @(posedge ref_clk);
        frame_eof <= 1'b0;
        // id and data only valid with the strobe
        rx_id <= ~FRAME_ID;
        rx_data <= ~64'h0;
        @(posedge ref_clk);
    endtask
endmodule

// ===== tb/cswk_ctrl_bench.sv
// self-checking bench for the selective-wake control block
`timescale 1ns/1ps
`include "cswk_map.vh"
module cswk_ctrl_bench;
    localparam logic [31:0] wake_id = 32'h0000_0123;
    logic       ref_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       in_sleep = 1'b0;
    logic       in_normal = 1'b0;
    logic       in_stop = 1'b0;
    logic       restart_from_normal = 1'b0;
    logic       fail_safe_entry = 1'b0;
    logic       tx_pin = 1'b1;
    wire        wake_pattern_det, frame_edl, frame_ok, frame_err, frame_eof, rx_pin_a, rx_pin_b;
    wire [31:0] rx_id;
    wire [63:0] rx_data;
    wire [7:0]  reg_rdata, tq_per_bit, osc_trim_value, osc_trim_option;
    wire [5:0]  sample_point_cfg;
    wire [2:0]  trx_mode;
    wire        selective_wake, fd_tolerant_en, fd_dom_bit, fd_skip, restart_req, wake_irq;
    int         mismatches = 0;
    int         n_tests = 0;
    int         n_restart = 0;
    int         n_irq = 0;
    int         n_skip = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (restart_req === 1'b1) n_restart <= n_restart + 1;
        if (wake_irq === 1'b1) n_irq <= n_irq + 1;
        if (fd_skip === 1'b1) n_skip <= n_skip + 1;
    end

    // short silence keeps the run brief
    cswk_ctrl #(.SIL_CYCLES(50)) i_cswk_ctrl (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_sleep(in_sleep),
        .in_normal(in_normal), .in_stop(in_stop), .restart_from_normal(restart_from_normal),
        .fail_safe_entry(fail_safe_entry), .wake_pattern_det(wake_pattern_det), .frame_edl(frame_edl),
        .frame_ok(frame_ok), .frame_err(frame_err), .frame_eof(frame_eof), .rx_id(rx_id), .rx_data(rx_data),
        .rx_pin_a(rx_pin_a), .rx_pin_b(rx_pin_b), .transmit_data_pin(tx_pin), .trx_mode(trx_mode),
        .selective_wake(selective_wake), .tq_per_bit(tq_per_bit), .sample_point_cfg(sample_point_cfg),
        .fd_tolerant_en(fd_tolerant_en), .fd_dom_bit(fd_dom_bit), .fd_skip(fd_skip),
        .osc_trim_value(osc_trim_value), .osc_trim_option(osc_trim_option), .restart_req(restart_req),
        .wake_irq(wake_irq));
    cswk_bus_node #(.FRAME_ID(wake_id)) i_cswk_bus_node (.ref_clk(ref_clk), .wake_pattern_det(wake_pattern_det),
        .frame_edl(frame_edl), .frame_ok(frame_ok), .frame_err(frame_err), .frame_eof(frame_eof),
        .rx_id(rx_id), .rx_data(rx_data), .rx_pin_a(rx_pin_a), .rx_pin_b(rx_pin_b));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
        @(posedge ref_clk);
    endtask
    task automatic pulse(input logic fs);
        if (fs) fail_safe_entry <= 1'b1;
        else restart_from_normal <= 1'b1;
        @(posedge ref_clk);
        fail_safe_entry <= 1'b0;
        restart_from_normal <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rc(`CSWK_MODE, 8'h00, 8'hff);
        rc(`CSWK_STAT, 8'h08, 8'h0f);
        rc(`CSWK_QPB, 8'h0a, 8'hff);
        rc(`CSWK_SPT, 8'h33, 8'hff);
        rc(`CSWK_FDFILT, 8'h04, 8'hff);
        rc(8'hff, 8'h00, 8'hff);
        wr(`CSWK_QPB, 8'h0c);
        wr(`CSWK_CLKSEL, 8'h01);
        chk(tq_per_bit, 8'h18);
        for (int m = 2; m < 8; m++) begin
            wr(`CSWK_MODE, 8'(m));
            wr(`CSWK_STAT, 8'h08);
            if (m > 4) chk({7'h0, selective_wake}, 8'h01);
            pulse(1'b0);
            rc(`CSWK_MODE, (m < 4) ? 8'h01 : (m == 4) ? 8'h04 : 8'h05, 8'hff);
            rc(`CSWK_STAT, (m > 4) ? 8'h08 : 8'h00, 8'h08);
        end
        wr(`CSWK_MODE, 8'h05);
        wr(`CSWK_STAT, 8'h08);
        pulse(1'b1);
        chk({7'h0, selective_wake}, 8'h00);
        wr(`CSWK_MODE, 8'h01);
        wr(`CSWK_STAT, 8'h0f);
        in_sleep <= 1'b1;
        i_cswk_bus_node.send(2'd0);
        chk(8'(n_restart), 8'h01);
        rc(`CSWK_STAT, 8'h03, 8'h07);
        rc(`CSWK_MODE, 8'h01, 8'hff);
        in_sleep <= 1'b0;
        in_stop <= 1'b1;
        // rearm before the next wake
        wr(`CSWK_MODE, 8'h00);
        wr(`CSWK_MODE, 8'h01);
        i_cswk_bus_node.send(2'd0);
        chk(8'(n_irq), 8'h01);
        in_stop <= 1'b0;
        in_normal <= 1'b1;
        wr(`CSWK_CTRL, 8'h00);
        repeat (3) i_cswk_bus_node.send(2'd2);
        rc(`CSWK_ECNT, 8'h03, 8'h3f);
        i_cswk_bus_node.send(2'd1);
        rc(`CSWK_ECNT, 8'h02, 8'h3f);
        i_cswk_bus_node.send(2'd3);
        rc(`CSWK_ECNT, 8'h03, 8'h3f);
        wr(`CSWK_CTRL, 8'h01);
        i_cswk_bus_node.send(2'd3);
        chk(8'(n_skip > 0), 8'h01);
        rc(`CSWK_ECNT, 8'h02, 8'h3f);
        i_cswk_bus_node.send(2'd1);
        rc(`CSWK_ECNT, 8'h01, 8'h3f);
        wr(`CSWK_CTRL, 8'h03);
        i_cswk_bus_node.send(2'd2);
        rc(`CSWK_ECNT, 8'h00, 8'h3f);
        rc(`CSWK_CTRL, 8'h03, 8'h03);
        repeat (60) @(posedge ref_clk);
        rc(`CSWK_CTRL, 8'h01, 8'h03);
        rc(`CSWK_STAT, 8'h10, 8'h10);
        wr(`CSWK_CTRL, 8'h00);
        wr(`CSWK_MODE, 8'h05);
        wr(`CSWK_STAT, 8'h0f);
        in_normal <= 1'b0;
        in_sleep <= 1'b1;
        repeat (32) i_cswk_bus_node.send(2'd2);
        chk(8'(n_restart), 8'h02);
        rc(`CSWK_ECNT, 8'h20, 8'h3f);
        rc(`CSWK_STAT, 8'h09, 8'h0f);
        wr(`CSWK_CTRL, 8'h03);
        wr(`CSWK_CTRL, 8'h00);
        wr(`CSWK_STAT, 8'h0f);
        for (int i = 0; i < 4; i++) begin
            wr(8'h10 + 8'(i), wake_id[8*i +: 8]);
            wr(8'h14 + 8'(i), 8'h00);
        end
        i_cswk_bus_node.send(2'd1);
        chk(8'(n_restart), 8'h03);
        rc(`CSWK_STAT, 8'h05, 8'h07);
        wr(`CSWK_TRIM, 8'h55);
        chk(osc_trim_value, 8'h00);
        wr(`CSWK_CTRL, 8'h38);
        wr(`CSWK_MODE, 8'h00);
        tx_pin <= 1'b0;
        repeat (50) @(posedge ref_clk);
        tx_pin <= 1'b1;
        wr(`CSWK_TRIM, 8'h55);
        wr(`CSWK_OPT, 8'haa);
        wr(`CSWK_CTRL, 8'h08);
        wr(`CSWK_TRIM, 8'h11);
        chk(osc_trim_value, 8'h55);
        chk(osc_trim_option, 8'haa);
        rc(`CSWK_OSC_H, 8'h00, 8'hff);
        rc(`CSWK_OSC_L, 8'h32, 8'hff);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
